/* File: hw/frs_regs.svh */
// Purpose: timing constants of the flash reset sequencer
// Assumes: core clock of 200 MHz
// Notes:   least times round up, longest times round down
`ifndef FRS_REGS_SVH
`define FRS_REGS_SVH

`define FRS_CLK_MHZ              200
`define FRS_POWER_UP_US          300
`define FRS_WARM_RESET_US        35
`define FRS_RESET_PULSE_NS       200
`define FRS_POST_RESET_HOLD_NS   50
`define FRS_RESET_SETUP_NS       50

`define FRS_POWER_UP_CYC    ((`FRS_POWER_UP_US * `FRS_CLK_MHZ))
`define FRS_WARM_RESET_CYC  ((`FRS_WARM_RESET_US * `FRS_CLK_MHZ))
`define FRS_RESET_PULSE_CYC ((`FRS_RESET_PULSE_NS * `FRS_CLK_MHZ + 999) / 1000)
`define FRS_POST_HOLD_CYC   ((`FRS_POST_RESET_HOLD_NS * `FRS_CLK_MHZ + 999) / 1000)
`define FRS_SETUP_CYC       ((`FRS_RESET_SETUP_NS * `FRS_CLK_MHZ + 999) / 1000)

`define FRS_CNT_W           17
`define FRS_PULSE_W         8

`endif

/* File: hw/frs_pkg.sv */
// Purpose: types of the flash reset sequencer
// Assumes: nothing
// Notes:   status travels as one packed struct
package frs_pkg;

  typedef enum logic [2:0] {
    FRS_WAIT_VCC,
    FRS_COLD,
    FRS_HOLD,
    FRS_READY,
    FRS_WARM
  } frs_state_t;

  typedef struct packed {
    logic ready;
    logic outputs_hiz;
    logic cmd_ignore;
    logic cold_ok;
  } frs_status_t;

endpackage

/* File: hw/frs_top.sv */
// Purpose: cold and warm reset sequencing of a serial flash device
// Assumes: supply monitor, reset pin and chip select arrive asynchronously
// Notes:   long delays are parameters so that simulation may shorten them
`timescale 1ns/1ps
`include "frs_regs.svh"

module frs_top
  import frs_pkg::*;
#(
  parameter int POWER_UP_CYC   = `FRS_POWER_UP_CYC,
  parameter int WARM_RESET_CYC = `FRS_WARM_RESET_CYC
) (
  input  wire logic  core_clk_in,
  input  wire logic  resetn_in,
  input  wire logic  vcc_ok_in,
  input  wire logic  reset_pin_n_in,
  input  wire logic  cs_n_in,
  input  wire logic  cold_fault_in,
  output frs_status_t status_out,
  output logic       abort_op_out,
  output logic       restore_regs_out,
  output logic       selected_out
);

  localparam logic [`FRS_CNT_W-1:0]   PU_LAST    = `FRS_CNT_W'(POWER_UP_CYC - 1);
  localparam logic [`FRS_CNT_W-1:0]   WARM_LAST  = `FRS_CNT_W'(WARM_RESET_CYC - 1);
  localparam logic [`FRS_PULSE_W-1:0] PULSE_LAST = `FRS_PULSE_W'(`FRS_RESET_PULSE_CYC - 1);

  logic [1:0]              vcc_sync_reg;
  logic [1:0]              rst_sync_reg;
  logic [1:0]              cs_sync_reg;
  logic                    vcc_ok;
  logic                    pin_low;
  logic                    cs_low;
  frs_state_t              state_reg;
  frs_state_t              state_next;
  logic [`FRS_CNT_W-1:0]   cnt_reg;
  logic [`FRS_PULSE_W-1:0] low_cnt_reg;
  logic                    pulse_valid;
  logic                    cold_ok_reg;
  logic                    cold_err_reg;

  // two-stage synchronisers; logic reads only the second stage, never the first
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      vcc_sync_reg <= 2'h0;
      rst_sync_reg <= 2'h3;
      cs_sync_reg  <= 2'h3;
    end else begin
      vcc_sync_reg <= {vcc_sync_reg[0], vcc_ok_in};
      rst_sync_reg <= {rst_sync_reg[0], reset_pin_n_in};
      cs_sync_reg  <= {cs_sync_reg[0], cs_n_in};
    end
  end

  assign vcc_ok  = vcc_sync_reg[1];
  assign pin_low = !rst_sync_reg[1];
  assign cs_low  = !cs_sync_reg[1];

  // low time of the reset pin; saturates so a held pin fires only once
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      low_cnt_reg <= '0;
    end else if (!pin_low) begin
      low_cnt_reg <= '0;
    end else if (low_cnt_reg != {`FRS_PULSE_W{1'b1}}) begin
      low_cnt_reg <= low_cnt_reg + `FRS_PULSE_W'(1);
    end
  end

  // fires in the single cycle the pulse reaches the minimum width
  assign pulse_valid = pin_low && (low_cnt_reg == PULSE_LAST);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FRS_WAIT_VCC: begin
        if (vcc_ok) begin
          state_next = FRS_COLD;
        end
      end
      FRS_COLD: begin
        // reset pin is read only when the count ends, to choose hold or ready
        if (cnt_reg == PU_LAST) begin
          state_next = pin_low ? FRS_HOLD : FRS_READY;
        end
      end
      FRS_HOLD: begin
        if (!pin_low) begin
          state_next = FRS_READY;
        end
      end
      FRS_READY: begin
        if (pulse_valid) begin
          state_next = cold_ok_reg ? FRS_WARM : FRS_COLD;
        end
      end
      FRS_WARM: begin
        if (cnt_reg == WARM_LAST) begin
          state_next = pin_low ? FRS_HOLD : FRS_READY;
        end
      end
      default: state_next = FRS_WAIT_VCC;
    endcase
    if (!vcc_ok) begin
      state_next = FRS_WAIT_VCC;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= FRS_WAIT_VCC;
    end else begin
      state_reg <= state_next;
    end
  end

  // one counter serves both sequences; they never overlap
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_reg <= '0;
    end else if (state_next != state_reg) begin
      cnt_reg <= '0;
    end else if (state_reg == FRS_COLD || state_reg == FRS_WARM) begin
      cnt_reg <= cnt_reg + `FRS_CNT_W'(1);
    end
  end

  // a fault seen at any time during the cold sequence spoils it
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cold_err_reg <= 1'b0;
      cold_ok_reg  <= 1'b0;
    end else if (state_reg != FRS_COLD && state_next == FRS_COLD) begin
      cold_err_reg <= cold_fault_in;
      cold_ok_reg  <= 1'b0;
    end else if (state_reg == FRS_COLD) begin
      cold_err_reg <= cold_err_reg | cold_fault_in;
      if (state_next != FRS_COLD) begin
        cold_ok_reg <= vcc_ok && !(cold_err_reg | cold_fault_in);
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      status_out       <= '{ready: 1'b0, outputs_hiz: 1'b1, cmd_ignore: 1'b1, cold_ok: 1'b0};
      abort_op_out     <= 1'b0;
      restore_regs_out <= 1'b0;
      selected_out     <= 1'b0;
    end else begin
      status_out.ready       <= (state_next == FRS_READY);
      status_out.outputs_hiz <= (state_next != FRS_READY);
      status_out.cmd_ignore  <= (state_next != FRS_READY);
      status_out.cold_ok     <= cold_ok_reg;
      abort_op_out           <= (state_reg == FRS_READY) && pulse_valid;
      restore_regs_out       <= (state_next == FRS_COLD || state_next == FRS_WARM)
                                && (state_next != state_reg);
      selected_out           <= (state_next == FRS_READY) && cs_low;
    end
  end

  property p_cold_full;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (state_reg == FRS_COLD && state_next != FRS_COLD && vcc_ok) |-> cnt_reg == PU_LAST;
  endproperty
  a_cold_full: assert property (p_cold_full) else $error("cold sequence cut short");

  property p_cold_bound;
    @(posedge core_clk_in) disable iff (!resetn_in)
      state_reg == FRS_COLD |-> cnt_reg <= PU_LAST;
  endproperty
  a_cold_bound: assert property (p_cold_bound) else $error("cold sequence overran");

  property p_cold_ignores_pin;
    @(posedge core_clk_in) disable iff (!resetn_in)
      state_reg == FRS_COLD |=> state_reg != FRS_WARM;
  endproperty
  a_cold_ignores_pin: assert property (p_cold_ignores_pin) else $error("warm during cold");

  property p_hold_while_low;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (state_reg == FRS_HOLD && pin_low && vcc_ok) |=> state_reg == FRS_HOLD && !status_out.ready;
  endproperty
  a_hold_while_low: assert property (p_hold_while_low) else $error("left hold early");

  property p_warm_start;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (state_reg == FRS_READY && pulse_valid && cold_ok_reg && vcc_ok)
        |=> state_reg == FRS_WARM && restore_regs_out && abort_op_out;
  endproperty
  a_warm_start: assert property (p_warm_start) else $error("warm reset not started");

  property p_failed_cold_rerun;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (state_reg == FRS_READY && pulse_valid && !cold_ok_reg && vcc_ok) |=> state_reg == FRS_COLD;
  endproperty
  a_failed_cold_rerun: assert property (p_failed_cold_rerun) else $error("no cold rerun");

  property p_warm_quiet;
    @(posedge core_clk_in) disable iff (!resetn_in)
      $rose(state_reg == FRS_WARM) |-> ##1 (status_out.outputs_hiz && status_out.cmd_ignore
        && !selected_out)[*4];
  endproperty
  a_warm_quiet: assert property (p_warm_quiet) else $error("outputs live during warm");

  property p_select;
    @(posedge core_clk_in) disable iff (!resetn_in)
      selected_out |-> $past(cs_low) && status_out.ready;
  endproperty
  a_select: assert property (p_select) else $error("selected while cs high");

  property p_short_pulse;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (state_reg == FRS_READY && (!pin_low || low_cnt_reg != PULSE_LAST) && vcc_ok)
        |=> state_reg == FRS_READY;
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("short pulse reset");

endmodule // frs_top

/* File: bench/frs_host_model.sv */
// Purpose: host side driver of the reset pin and chip select
// Assumes: changes only on the falling edge of the core clock
// Notes:   selects only once ready, so setup and hold always hold
`timescale 1ns/1ps
module frs_host_model (
  input  wire logic       clk_in,
  input  wire logic       rst_req_in,
  input  wire logic [7:0] width_in,
  input  wire logic       sel_req_in,
  input  wire logic       ready_in,
  output logic            reset_pin_n_out,
  output logic            cs_n_out,
  output logic            busy_out
);
  logic [7:0] low_reg  = 8'h00;
  logic [3:0] high_reg = 4'ha;
  logic       cs_reg   = 1'b1;
  assign reset_pin_n_out = (low_reg == 8'h00);
  assign busy_out        = !reset_pin_n_out || (high_reg < 4'ha);
  assign cs_n_out        = cs_reg;
  always @(negedge clk_in) begin
    if (low_reg != 8'h00) begin
      low_reg <= low_reg - 8'h01;
    end else if (rst_req_in && !busy_out) begin
      low_reg <= width_in;
    end
    // 10 cycles of 5 ns give the 50 ns high time after release
    if (!reset_pin_n_out) begin
      high_reg <= 4'h0;
    end else if (high_reg != 4'ha) begin
      high_reg <= high_reg + 4'h1;
    end
    cs_reg <= !(sel_req_in && ready_in && !busy_out);
  end
endmodule // frs_host_model

/* File: bench/test_flash_reset_sequencing.sv */
// Purpose: self-checking bench of the reset sequencer
// Assumes: long counts are shortened through the parameters
// Notes:   host timing comes from the partner model
`timescale 1ns/1ps
module test_flash_reset_sequencing;
  import frs_pkg::*;
  localparam int PU = 200;
  localparam int WR = 30;
  logic        clk = 1'b0, rstn = 1'b0, vcc = 1'b0, fault = 1'b0, req = 1'b0, sel = 1'b0;
  logic [7:0]  width = 8'h00;
  logic        pin_n, cs_n, busy, abort, restore, selected;
  frs_status_t st;
  int          bad_count = 0, cmp_count = 0, n_abort = 0, n_rest = 0, n, a0, r0;
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (abort === 1'b1) n_abort <= n_abort + 1;
    if (restore === 1'b1) n_rest <= n_rest + 1;
  end
  frs_top #(.POWER_UP_CYC(PU), .WARM_RESET_CYC(WR)) u_dut (.core_clk_in(clk), .resetn_in(rstn),
    .vcc_ok_in(vcc), .reset_pin_n_in(pin_n), .cs_n_in(cs_n), .cold_fault_in(fault),
    .status_out(st), .abort_op_out(abort), .restore_regs_out(restore), .selected_out(selected));
  frs_host_model u_host (.clk_in(clk), .rst_req_in(req), .width_in(width), .sel_req_in(sel),
    .ready_in(st.ready), .reset_pin_n_out(pin_n), .cs_n_out(cs_n), .busy_out(busy));
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check_bit(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic check_int(input string nm, input int e, input int g);
    cmp_count++;
    if (g != e) begin
      bad_count++;
      $display("unexpected %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // which 0 watches ready, 1 watches selected; n returns the cycles spent
  task automatic wait_on(input int which, input logic e, input int lim);
    n = 0;
    while (((which == 0) ? st.ready : selected) !== e) begin
      if (n == lim) begin
        bad_count++;
        $display("unexpected wait%0d expected %b seen timeout", which, e);
        print_verdict();
      end
      n++;
      @(negedge clk);
    end
    cmp_count++;
  endtask
  // rdy is the ready level expected first; ten idle cycles give the 50 ns setup after a reset
  task automatic pulse(input logic [7:0] w, input logic rdy);
    check_bit("pre_ready", rdy, st.ready);
    repeat (10) @(negedge clk);
    for (int i = 0; busy !== 1'b0; i++) begin
      if (i > 300) check_bit("host_busy", 1'b0, busy);
      if (i > 300) print_verdict();
      @(negedge clk);
    end
    width <= w;
    req   <= 1'b1;
    @(negedge clk);
    req <= 1'b0;
  endtask
  initial begin
    void'($urandom(34761));
    repeat (16) @(negedge clk);
    check_bit("rst_ready", 1'b0, st.ready);
    check_bit("rst_hiz", 1'b1, st.outputs_hiz);
    rstn <= 1'b1;
    pulse(8'hff, 1'b0);
    vcc <= 1'b1;
    repeat (PU + 20) @(negedge clk);
    check_bit("ready_held", 1'b0, st.ready);
    wait_on(0, 1'b1, 100);
    check_bit("pin_released", 1'b1, pin_n);
    check_int("cold_aborts", 0, n_abort);
    check_int("cold_restores", 1, n_rest);
    vcc <= 1'b0;
    wait_on(0, 1'b0, 4);
    repeat (4) @(negedge clk);
    vcc <= 1'b1;
    wait_on(0, 1'b1, PU + 8);
    check_bit("cold_len", 1'b1, logic'(n inside {[PU:PU + 4]}));
    sel <= 1'b1;
    wait_on(1, 1'b1, 6);
    // cold_ok trails the end of the cold sequence by one cycle, so look only now
    check_bit("cold_ok_good", 1'b1, st.cold_ok);
    sel <= 1'b0;
    wait_on(1, 1'b0, 6);
    sel <= 1'b1;
    a0 = n_abort;
    for (int i = 0; i < 5; i++) begin
      pulse((i == 4) ? 8'h26 : 8'(5 + $urandom_range(25)), 1'b1);
      repeat (45) @(negedge clk);
      check_bit("short_ready", 1'b1, st.ready);
    end
    check_int("short_aborts", a0, n_abort);
    r0 = n_rest;
    pulse(8'(45 + $urandom_range(19)), 1'b1);
    wait_on(0, 1'b0, 80);
    check_bit("hiz", 1'b1, st.outputs_hiz);
    check_bit("ignore", 1'b1, st.cmd_ignore);
    check_bit("sel_in_warm", 1'b0, selected);
    wait_on(0, 1'b1, WR + 8);
    check_bit("warm_len", 1'b1, logic'(n inside {[WR - 1:WR + 2]}));
    check_int("warm_abort", a0 + 1, n_abort);
    check_int("warm_restore", r0 + 1, n_rest);
    wait_on(1, 1'b1, 16);
    vcc   <= 1'b0;
    fault <= 1'b1;
    wait_on(0, 1'b0, 4);
    vcc <= 1'b1;
    wait_on(0, 1'b1, PU + 8);
    fault <= 1'b0;
    check_bit("cold_ok", 1'b0, st.cold_ok);
    pulse(8'h32, 1'b1);
    wait_on(0, 1'b0, 80);
    wait_on(0, 1'b1, PU + 8);
    check_bit("full_len", 1'b1, logic'(n inside {[PU - 1:PU + 3]}));
    print_verdict();
  end
endmodule // test_flash_reset_sequencing
